//--- src/port_mux.sv
`default_nettype none
`include "port_mux_defs.svh"

// Behaviour
// - Each eight-pin port pin can be software I/O, a logic output macrocell, or a logic input.
// - With the test port on, port C bits 0, 1, 5 and 6 carry TMS, TCK, TDI and TDO.
// - Port C bits 3 and 4 can carry programming status and programming error as well.
// - Port C bit 3 can drive flash ready/busy, showing when a program or erase completes.
// - Software may switch each eight-pin port software I/O output between push-pull and open drain.
// - Each three-pin port pin can be software I/O or a direct logic array input.
// - A three-pin port pin can drive a chip select from the logic array, no macrocell used.
// - Port D bit 1 can be the logic clock input shared by the logic array.
// - Port D bit 2 can be an active-low flash select; while it is high the flash is off.
module port_mux
  import port_mux_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] port_c_in_i,
  output logic [7:0] port_c_out_o,
  output logic [7:0] port_c_oe_o,
  input wire logic [2:0] port_d_in_i,
  output logic [2:0] port_d_out_o,
  output logic [2:0] port_d_oe_o,
  input wire logic [7:0] logic_output_macrocells_i,
  input wire logic [7:0] logic_output_macrocells_oe_i,
  input wire logic [2:0] logic_chip_select_i,
  output logic [7:0] port_c_logic_in_o,
  output logic [2:0] port_d_logic_in_o,
  output logic logic_clock_input_o,
  output logic test_mode_select_o,
  output logic test_clock_o,
  output logic test_data_in_o,
  input wire logic test_data_out_i,
  input wire logic test_data_out_oe_i,
  input wire logic programming_status_i,
  input wire logic programming_error_i,
  input wire logic flash_ready_i,
  output logic flash_disable_o,
  output logic irq_o
);

  mux_state_t s;
  mux_state_t next_s;

  // Register map, one 32-bit word each, with unused upper bits reading as zero.
  // Port C has data, direction (a one drives the pin) and open-drain words, and a
  // mode word with two bits a pin: software, logic output, logic input or unused.
  // Port D has data, direction and a mode word whose codes are software, logic
  // input, chip select or unused; it has no open-drain option.
  // Each port also has a read-only word that returns the present pin levels.
  // The alternate function word enables the test port, the status pins, the
  // ready/busy pin, the logic clock input and the flash select input.
  // Interrupt status is cleared by reading it, and the mask has the same layout.
  // Writes to read-only words are dropped quietly, while an unmapped address
  // answers with an error so that a stray software pointer shows up at once.

  logic access;
  logic setup;
  logic [1:0] irq_event;
  logic [1:0] irq_clear;
  logic [1:0] irq_status;
  logic [7:0] pc_sw_sel;
  logic [7:0] pc_alt_out;
  logic [7:0] pc_alt_oe;
  logic [2:0] pd_sw_sel;
  logic [2:0] pd_alt_out;
  logic [2:0] pd_alt_oe;
  logic [7:0] pc_drv_out;
  logic [7:0] pc_drv_oe;
  logic [2:0] pd_drv_out;
  logic [2:0] pd_drv_oe;

  // Mode of one pin from its two-bit field; shared by several decodes below.
  function automatic pc_mode_t pc_mode_of(input logic [15:0] modes, input int idx);
    pc_mode_t m;
    m = pc_mode_t'(modes[2*idx +: 2]);
    return m;
  endfunction : pc_mode_of

  function automatic pd_mode_t pd_mode_of(input logic [5:0] modes, input int idx);
    pd_mode_t m;
    m = pd_mode_t'(modes[2*idx +: 2]);
    return m;
  endfunction : pd_mode_of

  // The slave answers in the first access cycle, so pready is high there.
  // A master that stretched its access phase beyond that cycle would not be
  // answered again, so the bus must follow the plain two-cycle transfer.
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & s.pready;

  // Reading status clears only the bits that were actually returned, so an event
  // arriving after the setup cycle stays pending instead of vanishing.
  assign irq_clear = (access && !pwrite_i && paddr_i == `OFF_IRQ_STATUS)
    ? s.prdata[1:0] : 2'b00;

  // Both events are edges, so a flash that stays ready or a select pin that stays
  // high raises its flag once and not on every cycle.
  // Events: flash operation done (ready rises) and flash deselected by the select pin.
  assign irq_event[`IRQ_FLASH_DONE] = flash_ready_i & ~s.ready_q;
  assign irq_event[`IRQ_FLASH_DESELECT] = next_s.flash_off & ~s.flash_off;

  // The test port takes its pins whatever their mode bits say, so that a programmer
  // can still reach the device after software has misconfigured the port.
  // Eight-pin port routing; fixed alternate functions outrank the per-pin mode.
  always_comb
  begin
    pc_sw_sel = '0;
    pc_alt_out = '0;
    pc_alt_oe = '0;
    for (int i = 0; i < 8; i++)
    begin
      pc_sw_sel[i] = (pc_mode_of(s.pc_mode, i) == PC_SW_IO);
      pc_alt_out[i] = logic_output_macrocells_i[i];
      pc_alt_oe[i] = (pc_mode_of(s.pc_mode, i) == PC_LOGIC_OUT)
        & logic_output_macrocells_oe_i[i];
    end
    if (s.alt_ctrl[`ALT_TEST_PORT])
    begin
      // Bits 0, 1 and 5 become inputs; bit 6 is driven by the test port.
      pc_sw_sel[0] = 1'b0;
      pc_sw_sel[1] = 1'b0;
      pc_sw_sel[5] = 1'b0;
      pc_sw_sel[6] = 1'b0;
      pc_alt_oe[0] = 1'b0;
      pc_alt_oe[1] = 1'b0;
      pc_alt_oe[5] = 1'b0;
      pc_alt_out[6] = test_data_out_i;
      pc_alt_oe[6] = test_data_out_oe_i;
    end
    if (s.alt_ctrl[`ALT_TEST_STATUS])
    begin
      // The status pair takes bit 3 ahead of the ready/busy output.
      pc_sw_sel[3] = 1'b0;
      pc_sw_sel[4] = 1'b0;
      pc_alt_out[3] = programming_status_i;
      pc_alt_oe[3] = 1'b1;
      pc_alt_out[4] = programming_error_i;
      pc_alt_oe[4] = 1'b1;
    end
    else if (s.alt_ctrl[`ALT_READY_BUSY])
    begin
      pc_sw_sel[3] = 1'b0;
      pc_alt_out[3] = flash_ready_i;
      pc_alt_oe[3] = 1'b1;
    end
  end

  // A clock or flash select pin is never driven, so the board signal on it cannot
  // fight the device even if software leaves that pin's direction bit set.
  // Three-pin port routing; clock and flash select inputs outrank the per-pin mode.
  always_comb
  begin
    pd_sw_sel = '0;
    pd_alt_out = '0;
    pd_alt_oe = '0;
    for (int i = 0; i < 3; i++)
    begin
      pd_sw_sel[i] = (pd_mode_of(s.pd_mode, i) == PD_SW_IO);
      // A chip select is routed straight from the array, no macrocell in the path.
      pd_alt_out[i] = logic_chip_select_i[i];
      pd_alt_oe[i] = (pd_mode_of(s.pd_mode, i) == PD_CHIP_SELECT);
    end
    if (s.alt_ctrl[`ALT_CLOCK_IN])
    begin
      pd_sw_sel[1] = 1'b0;
      pd_alt_oe[1] = 1'b0;
    end
    if (s.alt_ctrl[`ALT_FLASH_SELECT])
    begin
      pd_sw_sel[2] = 1'b0;
      pd_alt_oe[2] = 1'b0;
    end
  end

  // Pin drivers honour the open-drain choice only on software pins.
  io_drive #(
    .W(8)
  ) u_pc_drive (
    .sw_sel_i(pc_sw_sel),
    .sw_data_i(s.pc_data),
    .sw_dir_i(s.pc_dir),
    .sw_od_i(s.pc_od),
    .alt_out_i(pc_alt_out),
    .alt_oe_i(pc_alt_oe),
    .out_o(pc_drv_out),
    .oe_o(pc_drv_oe)
  );

  // The three-pin port has no open-drain option, so its outputs are push-pull.
  io_drive #(
    .W(3)
  ) u_pd_drive (
    .sw_sel_i(pd_sw_sel),
    .sw_data_i(s.pd_data),
    .sw_dir_i(s.pd_dir),
    .sw_od_i(3'b000),
    .alt_out_i(pd_alt_out),
    .alt_oe_i(pd_alt_oe),
    .out_o(pd_drv_out),
    .oe_o(pd_drv_oe)
  );

  // Sticky event flags, cleared by reading them, gated by the mask onto irq_o.
  // Masked flags still set, so software can poll them with the interrupt off.
  irq_sticky u_irq (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .event_i(irq_event),
    .clear_i(irq_clear),
    .mask_i(s.irq_mask),
    .status_o(irq_status),
    .irq_o(irq_o)
  );

  // Next state: register writes, read data, and every registered pin and side output.
  always_comb
  begin
    next_s = s;
    if (access && pwrite_i)
    begin
      case (paddr_i)
        `OFF_PC_DATA: next_s.pc_data = pwdata_i[7:0];
        `OFF_PC_DIR: next_s.pc_dir = pwdata_i[7:0];
        `OFF_PC_OD: next_s.pc_od = pwdata_i[7:0];
        `OFF_PC_MODE: next_s.pc_mode = pwdata_i[15:0];
        `OFF_PD_DATA: next_s.pd_data = pwdata_i[2:0];
        `OFF_PD_DIR: next_s.pd_dir = pwdata_i[2:0];
        `OFF_PD_MODE: next_s.pd_mode = pwdata_i[5:0];
        `OFF_ALT_CTRL: next_s.alt_ctrl = pwdata_i[4:0];
        `OFF_IRQ_MASK: next_s.irq_mask = pwdata_i[1:0];
        default: next_s.pc_data = s.pc_data;
      endcase
    end
    // Read data is prepared in the setup cycle so that it comes from a flop.
    // Pin levels are therefore those of the setup cycle; a pin that toggles during
    // the access cycle shows up only on the next read.
    next_s.pready = setup;
    next_s.pslverr = 1'b0;
    if (setup)
    begin
      next_s.prdata = `RST_WORD;
      case (paddr_i)
        `OFF_PC_DATA: next_s.prdata[7:0] = s.pc_data;
        `OFF_PC_DIR: next_s.prdata[7:0] = s.pc_dir;
        `OFF_PC_OD: next_s.prdata[7:0] = s.pc_od;
        `OFF_PC_MODE: next_s.prdata[15:0] = s.pc_mode;
        `OFF_PC_PINS: next_s.prdata[7:0] = port_c_in_i;
        `OFF_PD_DATA: next_s.prdata[2:0] = s.pd_data;
        `OFF_PD_DIR: next_s.prdata[2:0] = s.pd_dir;
        `OFF_PD_MODE: next_s.prdata[5:0] = s.pd_mode;
        `OFF_PD_PINS: next_s.prdata[2:0] = port_d_in_i;
        `OFF_ALT_CTRL: next_s.prdata[4:0] = s.alt_ctrl;
        `OFF_IRQ_STATUS: next_s.prdata[1:0] = irq_status;
        `OFF_IRQ_MASK: next_s.prdata[1:0] = s.irq_mask;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    // Registered pin drive, one cycle behind the selecting state and sources.
    next_s.pc_out = pc_drv_out;
    next_s.pc_oe = pc_drv_oe;
    next_s.pd_out = pd_drv_out;
    next_s.pd_oe = pd_drv_oe;
    // Logic array inputs; both ports are direct, with no input macrocell flop, apart
    // from the output flop every top-level output carries.
    for (int i = 0; i < 8; i++)
    begin
      next_s.pc_logic_in[i] = (pc_mode_of(s.pc_mode, i) == PC_LOGIC_IN)
        & port_c_in_i[i];
    end
    for (int i = 0; i < 3; i++)
    begin
      next_s.pd_logic_in[i] = (pd_mode_of(s.pd_mode, i) == PD_LOGIC_IN)
        & port_d_in_i[i];
    end
    // Test port inputs read zero unless the test port owns those pins.
    next_s.tms = s.alt_ctrl[`ALT_TEST_PORT] & port_c_in_i[0];
    next_s.tck = s.alt_ctrl[`ALT_TEST_PORT] & port_c_in_i[1];
    next_s.tdi = s.alt_ctrl[`ALT_TEST_PORT] & port_c_in_i[5];
    next_s.clk_in = s.alt_ctrl[`ALT_CLOCK_IN] & port_d_in_i[1];
    // A high level on the select pin turns the flash off to save power.
    next_s.flash_off = s.alt_ctrl[`ALT_FLASH_SELECT] & port_d_in_i[2];
    next_s.ready_q = flash_ready_i;
  end

  // All control state clears on reset; pins start undriven.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.pc_data <= `RST_BYTE;
      s.pc_dir <= `RST_BYTE;
      s.pc_od <= `RST_BYTE;
      s.pc_mode <= `RST_PC_MODE;
      s.pd_data <= `RST_PD;
      s.pd_dir <= `RST_PD;
      s.pd_mode <= `RST_PD_MODE;
      s.alt_ctrl <= `RST_ALT;
      s.prdata <= `RST_WORD;
      // Ready idles high, so its edge detector starts high as well; starting low
      // would report a finished flash operation right after every reset.
      s.ready_q <= `RST_READY;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Every pin and side output lags its inputs by one flop. That costs a cycle on
  // the logic array paths, but keeps each output free of glitches while the mode
  // registers change underneath it.
  // Outputs come straight from the state flops.
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign port_c_out_o = s.pc_out;
  assign port_c_oe_o = s.pc_oe;
  assign port_d_out_o = s.pd_out;
  assign port_d_oe_o = s.pd_oe;
  assign port_c_logic_in_o = s.pc_logic_in;
  assign port_d_logic_in_o = s.pd_logic_in;
  assign logic_clock_input_o = s.clk_in;
  assign test_mode_select_o = s.tms;
  assign test_clock_o = s.tck;
  assign test_data_in_o = s.tdi;
  assign flash_disable_o = s.flash_off;

endmodule : port_mux

`default_nettype wire

//--- src/port_mux_defs.svh
`ifndef PORT_MUX_DEFS_SVH
`define PORT_MUX_DEFS_SVH

// Register byte offsets on the APB slave.
`define OFF_PC_DATA 8'h00
`define OFF_PC_DIR 8'h04
`define OFF_PC_OD 8'h08
`define OFF_PC_MODE 8'h0C
`define OFF_PC_PINS 8'h10
`define OFF_PD_DATA 8'h14
`define OFF_PD_DIR 8'h18
`define OFF_PD_MODE 8'h1C
`define OFF_PD_PINS 8'h20
`define OFF_ALT_CTRL 8'h24
`define OFF_IRQ_STATUS 8'h28
`define OFF_IRQ_MASK 8'h2C

// Field positions of the alternate function control register.
`define ALT_TEST_PORT 0
`define ALT_TEST_STATUS 1
`define ALT_READY_BUSY 2
`define ALT_CLOCK_IN 3
`define ALT_FLASH_SELECT 4

// Field positions of the interrupt status and mask registers.
`define IRQ_FLASH_DONE 0
`define IRQ_FLASH_DESELECT 1
`define IRQ_WIDTH 2

// Reset values.
`define RST_BYTE 8'h00
`define RST_PD 3'h0
`define RST_PC_MODE 16'h0000
`define RST_PD_MODE 6'h00
`define RST_ALT 5'h00
`define RST_WORD 32'h0000_0000
`define RST_READY 1'b1

`endif

//--- src/port_mux_pkg.sv
`default_nettype none

package port_mux_pkg;

  // Function of one eight-pin port pin, two bits per pin.
  typedef enum logic [1:0] {PC_SW_IO, PC_LOGIC_OUT, PC_LOGIC_IN, PC_UNUSED} pc_mode_t;

  // Function of one three-pin port pin, two bits per pin.
  typedef enum logic [1:0] {PD_SW_IO, PD_LOGIC_IN, PD_CHIP_SELECT, PD_UNUSED} pd_mode_t;

  typedef struct packed {
    logic [1:0] status;
    logic irq;
  } irq_state_t;

  typedef struct packed {
    logic [7:0] pc_data;
    logic [7:0] pc_dir;
    logic [7:0] pc_od;
    logic [15:0] pc_mode;
    logic [2:0] pd_data;
    logic [2:0] pd_dir;
    logic [5:0] pd_mode;
    logic [4:0] alt_ctrl;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
    logic [2:0] pd_out;
    logic [2:0] pd_oe;
    logic [7:0] pc_logic_in;
    logic [2:0] pd_logic_in;
    logic tms;
    logic tck;
    logic tdi;
    logic clk_in;
    logic flash_off;
    logic ready_q;
  } mux_state_t;

endpackage : port_mux_pkg

`default_nettype wire

//--- src/io_drive.sv
`default_nettype none

module io_drive #(
  parameter int W = 8
) (
  input wire logic [W-1:0] sw_sel_i,
  input wire logic [W-1:0] sw_data_i,
  input wire logic [W-1:0] sw_dir_i,
  input wire logic [W-1:0] sw_od_i,
  input wire logic [W-1:0] alt_out_i,
  input wire logic [W-1:0] alt_oe_i,
  output logic [W-1:0] out_o,
  output logic [W-1:0] oe_o
);

  // Software pins drive push-pull, or only a low level when open drain is chosen.
  // Pins given to another function ignore the software bits entirely.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (sw_sel_i[i])
      begin
        out_o[i] = sw_od_i[i] ? 1'b0 : sw_data_i[i];
        oe_o[i] = sw_dir_i[i] & (~sw_od_i[i] | ~sw_data_i[i]);
      end
      else
      begin
        out_o[i] = alt_out_i[i];
        oe_o[i] = alt_oe_i[i];
      end
    end
  end

endmodule : io_drive

`default_nettype wire

//--- src/irq_sticky.sv
`default_nettype none
`include "port_mux_defs.svh"

module irq_sticky
  import port_mux_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] event_i,
  input wire logic [1:0] clear_i,
  input wire logic [1:0] mask_i,
  output logic [1:0] status_o,
  output logic irq_o
);

  irq_state_t s;
  irq_state_t next_s;

  // A new event wins over a clear in the same cycle, so no event is lost.
  always_comb
  begin
    next_s = s;
    next_s.status = (s.status & ~clear_i) | event_i;
    next_s.irq = |(next_s.status & mask_i);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign status_o = s.status;
  assign irq_o = s.irq;

endmodule : irq_sticky

`default_nettype wire

//--- dv/port_mux_checker.sv
`default_nettype none
`include "port_mux_defs.svh"
// Watches the pin multiplexer at its ports and shadows the alternate function setting.
module port_mux_checker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] port_c_in_i,
  input wire logic [7:0] port_c_out_o,
  input wire logic [7:0] port_c_oe_o,
  input wire logic [2:0] port_d_in_i,
  input wire logic [2:0] port_d_oe_o,
  input wire logic test_clock_o,
  input wire logic test_data_out_i,
  input wire logic test_data_out_oe_i,
  input wire logic programming_error_i,
  input wire logic flash_ready_i,
  input wire logic logic_clock_input_o,
  input wire logic flash_disable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] alt_q;
  // The control register is not visible at the ports, so a shadow copy is kept here.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      alt_q <= 5'h0;
    else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `OFF_ALT_CTRL)
      alt_q <= pwdata_i[4:0];
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // A transfer answers in the first access cycle and for one cycle only.
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  property p_ready;
    s_setup |=> s_answer;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  property p_slverr;
    pslverr_o |-> pready_o;
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");
  property p_tck;
    $past(alt_q[0]) |-> test_clock_o == $past(port_c_in_i[1]) && !port_c_oe_o[1];
  endproperty
  a_tck: assert property (p_tck) else $error("test clock pin wrong");
  property p_tdo;
    $past(alt_q[0]) |-> port_c_oe_o[6] == $past(test_data_out_oe_i)
      && port_c_out_o[6] == $past(test_data_out_i);
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data out pin wrong");
  property p_perr;
    $past(alt_q[1]) |-> port_c_oe_o[4] && port_c_out_o[4] == $past(programming_error_i);
  endproperty
  a_perr: assert property (p_perr) else $error("programming error pin wrong");
  property p_busy;
    $past(alt_q[2]) && !$past(alt_q[1]) |-> port_c_oe_o[3]
      && port_c_out_o[3] == $past(flash_ready_i);
  endproperty
  a_busy: assert property (p_busy) else $error("ready busy pin wrong");
  property p_clk;
    $past(alt_q[3]) |-> logic_clock_input_o == $past(port_d_in_i[1]) && !port_d_oe_o[1];
  endproperty
  a_clk: assert property (p_clk) else $error("logic clock input wrong");
  property p_off;
    flash_disable_o == ($past(alt_q[4]) && $past(port_d_in_i[2]));
  endproperty
  a_off: assert property (p_off) else $error("flash disable wrong");
  property p_csi;
    $past(alt_q[4]) |-> !port_d_oe_o[2];
  endproperty
  a_csi: assert property (p_csi) else $error("flash select pin driven");
endmodule : port_mux_checker

bind port_mux port_mux_checker chk_u (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .port_c_in_i, .port_c_out_o, .port_c_oe_o,
  .port_d_in_i, .port_d_oe_o, .test_clock_o, .test_data_out_i, .test_data_out_oe_i,
  .programming_error_i, .flash_ready_i, .logic_clock_input_o, .flash_disable_o);
`default_nettype wire

//--- dv/board_model.sv
`default_nettype none
// Board side of both ports: each pin is the device drive, else the board drive, else pull-up.
module board_model (
  input wire logic [7:0] c_out_i,
  input wire logic [7:0] c_oe_i,
  input wire logic [7:0] c_ext_i,
  input wire logic [7:0] c_ext_en_i,
  input wire logic [2:0] d_out_i,
  input wire logic [2:0] d_oe_i,
  input wire logic [2:0] d_ext_i,
  input wire logic [2:0] d_ext_en_i,
  output logic [7:0] c_pin_o,
  output logic [2:0] d_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pins go to the pull-up level, so a stale value can never pass for a drive.
  always_comb
  begin
    c_pin_o = (c_oe_i & c_out_i) | (~c_oe_i & ~c_ext_en_i) | (~c_oe_i & c_ext_en_i & c_ext_i);
    d_pin_o = (d_oe_i & d_out_i) | (~d_oe_i & ~d_ext_en_i)
      | (~d_oe_i & d_ext_en_i & d_ext_i);
  end
endmodule : board_model
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
`include "port_mux_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, logic_clock_input_o, flash_disable_o, irq_o;
  logic test_mode_select_o, test_clock_o, test_data_in_o;
  logic [7:0] port_c_in_i, port_c_out_o, port_c_oe_o, port_c_logic_in_o;
  logic [2:0] port_d_in_i, port_d_out_o, port_d_oe_o, port_d_logic_in_o;
  logic [7:0] logic_output_macrocells_i = 8'h00;
  logic [7:0] logic_output_macrocells_oe_i = 8'h00;
  logic [2:0] logic_chip_select_i = 3'h0;
  logic test_data_out_i = 1'b1;
  logic test_data_out_oe_i = 1'b1;
  logic programming_status_i = 1'b1;
  logic programming_error_i = 1'b0;
  logic flash_ready_i = 1'b0;
  logic [7:0] c_ext = 8'h00;
  logic [7:0] c_ext_en = 8'h00;
  logic [2:0] d_ext = 3'h6;
  logic [2:0] d_ext_en = 3'h0;
  logic [7:0] offs [9] = '{`OFF_PC_DATA, `OFF_PC_DIR, `OFF_PC_OD, `OFF_PC_MODE, `OFF_PD_DATA,
    `OFF_PD_DIR, `OFF_PD_MODE, `OFF_ALT_CTRL, `OFF_IRQ_MASK};
  int err_total = 0;
  int checks_done = 0;

  port_mux dut_u (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .port_c_in_i, .port_c_out_o, .port_c_oe_o, .port_d_in_i,
    .port_d_out_o, .port_d_oe_o, .logic_output_macrocells_i, .logic_output_macrocells_oe_i,
    .logic_chip_select_i, .port_c_logic_in_o, .port_d_logic_in_o, .logic_clock_input_o,
    .test_mode_select_o, .test_clock_o, .test_data_in_o, .test_data_out_i, .test_data_out_oe_i,
    .programming_status_i, .programming_error_i, .flash_ready_i, .flash_disable_o, .irq_o);
  board_model board_u (.c_out_i(port_c_out_o), .c_oe_i(port_c_oe_o), .c_ext_i(c_ext),
    .c_ext_en_i(c_ext_en), .d_out_i(port_d_out_o), .d_oe_i(port_d_oe_o), .d_ext_i(d_ext),
    .d_ext_en_i(d_ext_en), .c_pin_o(port_c_in_i), .d_pin_o(port_d_in_i));

  // Free-running 100 MHz clock.
  always #5 ref_clk_i = ~ref_clk_i;

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One bus transfer; the request stands until pready is seen high, then one idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, exp_err}, {31'h0, e});
  endtask : rdc

  // Pins follow a register write two edges later; three leaves a margin.
  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
  endtask : settle

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Main sequence: reset, then one block of calls per pin function.
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    foreach (offs[i]) rdc(offs[i], 32'h0000_0000, 1'b0);
    rdc(8'h30, 32'h0000_0000, 1'b1);
    $display("test reset done");
    wr(`OFF_PC_DIR, 32'h0000_00ff);
    wr(`OFF_PC_DATA, 32'h0000_00a5);
    settle();
    chk("c_sw", 32'h0000_a5ff, 32'({port_c_out_o, port_c_oe_o}));
    wr(`OFF_PC_OD, 32'h0000_00ff);
    settle();
    chk("c_od", 32'h0000_005a, 32'({port_c_out_o, port_c_oe_o}));
    rdc(`OFF_PC_PINS, 32'h0000_00a5, 1'b0);
    $display("test software io done");
    logic_output_macrocells_i <= 8'h3c;
    logic_output_macrocells_oe_i <= 8'hff;
    wr(`OFF_PC_MODE, 32'h0000_5555);
    settle();
    chk("c_macro", 32'h0000_3cff, 32'({port_c_out_o, port_c_oe_o}));
    c_ext <= 8'h5a;
    c_ext_en <= 8'hff;
    wr(`OFF_PC_MODE, 32'h0000_aaaa);
    settle();
    chk("c_in", 32'h0000_5a00, 32'({port_c_logic_in_o, port_c_oe_o}));
    d_ext_en <= 3'h7;
    logic_chip_select_i <= 3'h5;
    wr(`OFF_PD_MODE, 32'h0000_0015);
    settle();
    chk("d_in", 32'h0000_0030, 32'({port_d_logic_in_o, port_d_oe_o}));
    wr(`OFF_PD_MODE, 32'h0000_002a);
    settle();
    chk("d_cs", 32'h0000_002f, 32'({port_d_out_o, port_d_oe_o}));
    $display("test logic modes done");
    wr(`OFF_PD_MODE, 32'h0000_0000);
    wr(`OFF_PC_MODE, 32'h0000_0000);
    c_ext <= 8'h22;
    c_ext_en <= 8'h23;
    wr(`OFF_ALT_CTRL, 32'h0000_0003);
    settle();
    chk("test_in", 32'h0000_0003,
      32'({test_mode_select_o, test_clock_o, test_data_in_o}));
    chk("test_out", 32'h0000_4858,
      32'({port_c_out_o & 8'h58, port_c_oe_o & 8'h58}));
    $display("test serial port done");
    c_ext_en <= 8'h00;
    wr(`OFF_IRQ_MASK, 32'h0000_0001);
    wr(`OFF_ALT_CTRL, 32'h0000_0004);
    settle();
    chk("busy", 32'h0000_0002, 32'({port_c_oe_o[3], port_c_out_o[3]}));
    flash_ready_i <= 1'b1;
    settle();
    chk("ready", 32'h0000_0007, 32'({port_c_oe_o[3], port_c_out_o[3], irq_o}));
    rdc(`OFF_IRQ_STATUS, 32'h0000_0001, 1'b0);
    settle();
    chk("irq_clr", 32'h0000_0000, {31'h0, irq_o});
    wr(`OFF_IRQ_MASK, 32'h0000_0000);
    flash_ready_i <= 1'b0;
    settle();
    flash_ready_i <= 1'b1;
    settle();
    chk("irq_mask", 32'h0000_0000, {31'h0, irq_o});
    rdc(`OFF_IRQ_STATUS, 32'h0000_0001, 1'b0);
    $display("test ready busy done");
    wr(`OFF_IRQ_MASK, 32'h0000_0002);
    wr(`OFF_ALT_CTRL, 32'h0000_0018);
    settle();
    chk("d_alt", 32'h0000_001c,
      32'({logic_clock_input_o, flash_disable_o, irq_o, port_d_oe_o[2:1]}));
    rdc(`OFF_IRQ_STATUS, 32'h0000_0002, 1'b0);
    d_ext <= 3'h0;
    settle();
    chk("d_low", 32'h0000_0000, 32'({logic_clock_input_o, flash_disable_o}));
    $display("test port d functions done");
    summarize();
  end

  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    summarize();
  end
endmodule : tb
`default_nettype wire
